/* dpcs_consts.svh */
`ifndef DPCS_CONSTS_SVH
`define DPCS_CONSTS_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DPCS_CLK_HZ          200000000
`define DPCS_DELAY_MS        3000
`define DPCS_FAIL_MS         3000
`define DPCS_LATCH_TO_MS     4000
`define DPCS_CLOSE_TO_MS     15000
`define DPCS_DEBOUNCE_US     10000
`define DPCS_FLASH_MS        250
`define DPCS_ACT_PULSE_MS    500
`define DPCS_MS_CYC          (`DPCS_CLK_HZ / 1000)
`define DPCS_US_CYC          (`DPCS_CLK_HZ / 1000000)
`define DPCS_DELAY_CYC       (`DPCS_DELAY_MS * `DPCS_MS_CYC)
`define DPCS_FAIL_CYC        (`DPCS_FAIL_MS * `DPCS_MS_CYC)
`define DPCS_LATCH_TO_CYC    (`DPCS_LATCH_TO_MS * `DPCS_MS_CYC)
`define DPCS_CLOSE_TO_CYC    (64'(`DPCS_CLOSE_TO_MS) * `DPCS_MS_CYC)
`define DPCS_DEBOUNCE_CYC    (`DPCS_DEBOUNCE_US * `DPCS_US_CYC)
`define DPCS_FLASH_CYC       (`DPCS_FLASH_MS * `DPCS_MS_CYC)
`define DPCS_ACT_PULSE_CYC   (`DPCS_ACT_PULSE_MS * `DPCS_MS_CYC)
// ---------------------------------------------------------------
// selector codes and input count
// ---------------------------------------------------------------
`define DPCS_SEL_LATCH       2'h1
`define DPCS_SEL_CLOSE       2'h2
`define DPCS_SEL_BOTH        2'h3
`define DPCS_NUM_IN          9
`endif

/* dpcs_pkg.sv */
package dpcs_pkg;
  typedef enum logic [1:0] {
    dpcs_sel_none,
    dpcs_sel_latch,
    dpcs_sel_close,
    dpcs_sel_both
  } dpcs_sel_t;

  typedef enum {
    dpcs_idle,
    dpcs_delay,
    dpcs_drive,
    dpcs_hold,
    dpcs_fail
  } dpcs_state_t;

  typedef struct packed {
    logic cancel;
    logic closed;
    logic backcheck;
    logic latch;
    logic activation;
    logic trigger;
    logic hold_jmp;
    logic bk_jmp;
    logic overcurrent;
  } dpcs_in_t;

  typedef struct packed {
    logic latch;
    logic close;
    logic both;
  } dpcs_led_sel_t;
endpackage

/* dpcs_debounce.sv */
`timescale 1ns/1ps
`include "dpcs_consts.svh"
module dpcs_debounce #(
  parameter int CNT = 2000000
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // raw and clean level
  input  wire logic raw,
  output logic      clean
);
  localparam int W = $clog2(CNT + 1);
  logic         sync0;
  logic         sync1;
  logic [W-1:0] cnt;

  initial begin
    if (CNT < 1) $error("debounce count must be at least one");
  end

  // ---------------------------------------------------------------
  // two stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync0 <= 1'b0;
      sync1 <= 1'b0;
    end else begin
      sync0 <= raw;
      sync1 <= sync0;
    end
  end

  // ---------------------------------------------------------------
  // stable-count filter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt   <= '0;
      clean <= 1'b0;
    end else if (sync1 == clean) begin
      cnt <= '0;
    end else if (cnt == W'(CNT - 1)) begin
      cnt   <= '0;
      clean <= sync1;
    end else begin
      cnt <= cnt + W'(1);
    end
  end
endmodule

/* dpcs_sequencer.sv */
// Behaviour
// - cancel input aborts any power close and blocks engaging
// - door closed ends power close; with hold option, start hold
// - hold ends on activation, cancel, door opening or jumper removal
// - back-check blocks engaging unless back-check option fitted
// - back-check option allows engaging only with selector at close
// - latch input lets power close engage only after trigger met
// - latch selector allows power close only in latch area
// - close selector allows power close only in close area
// - both selector allows latch and close areas
// - hold jumper plus door closed gives constant hold force
// - force light flashes while holding
// - close area needs back-check switch seen first
// - engage loads time-out, 4 s in latch area, 15 s in close area
// - trigger light on whenever closing speed meets threshold
// - force light steady while driving
// - overcurrent lights red, cancels, pulses activation output
// - 3 s trigger delay, cancelled and restarted by trigger loss
// - power close disabled 3 s after overcurrent
// - activation input cancels power close
// - latch-area force is half of configured force
`timescale 1ns/1ps
`include "dpcs_consts.svh"
module dpcs_sequencer
  import dpcs_pkg::*;
#(
  parameter int DELAY_CYC    = `DPCS_DELAY_CYC,
  parameter int FAIL_CYC     = `DPCS_FAIL_CYC,
  parameter int LATCH_TO_CYC = `DPCS_LATCH_TO_CYC,
  parameter longint CLOSE_TO_CYC = `DPCS_CLOSE_TO_CYC,
  parameter int DEB_CYC      = `DPCS_DEBOUNCE_CYC,
  parameter int FLASH_CYC    = `DPCS_FLASH_CYC,
  parameter int ACT_CYC      = `DPCS_ACT_PULSE_CYC,
  parameter int FORCE_W      = 8
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // contacts, jumpers, selector, sensing
  input  wire dpcs_in_t           raw_in,
  input  wire logic [1:0]         selector,
  input  wire logic [FORCE_W-1:0] force_setting,
  // motor force command
  output logic                    power_close_on,
  output logic [FORCE_W-1:0]      power_close_force,
  output logic                    hold_on,
  // activation back to main control
  output logic                    activation_out,
  // indicators
  output logic                    led_trigger,
  output logic                    led_force,
  output logic                    led_fail,
  output dpcs_led_sel_t           led_sel
);
  localparam int CW = $clog2(CLOSE_TO_CYC + DELAY_CYC + FAIL_CYC + 1);

  dpcs_in_t    din;
  dpcs_state_t state;
  dpcs_sel_t   sel;
  logic [CW-1:0] tmr;
  logic [CW-1:0] act_cnt;
  logic [CW-1:0] flash_cnt;
  logic        flash;
  logic        bk_seen;
  logic        latch_mode;
  logic        area_ok;
  logic        block;
  logic        stop_drive;
  logic        next_hold;

  initial begin
    if (DELAY_CYC < 1 || FAIL_CYC < 1 || LATCH_TO_CYC < 1 ||
        CLOSE_TO_CYC < LATCH_TO_CYC || FLASH_CYC < 1 || ACT_CYC < 1 ||
        FORCE_W < 2)
      $error("dpcs_sequencer parameters out of range");
  end

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `DPCS_NUM_IN; gi++) begin : g_deb
      dpcs_debounce #(.CNT(DEB_CYC)) u_deb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .raw     (raw_in[gi]),
        .clean   (din[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // selector and area permission
  // ---------------------------------------------------------------
  always_comb begin
    unique case (selector)
      `DPCS_SEL_LATCH: sel = dpcs_sel_latch;
      `DPCS_SEL_CLOSE: sel = dpcs_sel_close;
      `DPCS_SEL_BOTH:  sel = dpcs_sel_both;
      default:         sel = dpcs_sel_none;
    endcase
  end

  always_comb begin
    area_ok = 1'b0;
    if (din.backcheck) begin
      area_ok = din.bk_jmp && sel == dpcs_sel_close;
    end else if (din.latch) begin
      area_ok = sel == dpcs_sel_latch || sel == dpcs_sel_both;
    end else begin
      area_ok = bk_seen &&
                (sel == dpcs_sel_close || sel == dpcs_sel_both);
    end
  end

  assign block      = din.cancel || din.activation || din.closed;
  assign latch_mode = din.latch && !din.backcheck;
  assign stop_drive = block || din.overcurrent || tmr == '0;
  assign next_hold  = din.closed && din.hold_jmp &&
                      !din.cancel && !din.activation;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bk_seen <= 1'b0;
    end else if (din.backcheck) begin
      bk_seen <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= dpcs_idle;
      tmr   <= '0;
    end else begin
      unique case (state)
        dpcs_idle, dpcs_hold: begin
          if (next_hold) begin
            state <= dpcs_hold;
          end else if (!block && din.trigger && area_ok) begin
            state <= dpcs_delay;
            tmr   <= CW'(DELAY_CYC);
          end else begin
            state <= dpcs_idle;
          end
        end
        dpcs_delay: begin
          if (block || !din.trigger || !area_ok) begin
            state <= dpcs_idle;
          end else if (tmr == CW'(1)) begin
            state <= dpcs_drive;
            tmr   <= latch_mode ? CW'(LATCH_TO_CYC) : CW'(CLOSE_TO_CYC);
          end else begin
            tmr <= tmr - CW'(1);
          end
        end
        dpcs_drive: begin
          if (din.overcurrent) begin
            state <= dpcs_fail;
            tmr   <= CW'(FAIL_CYC);
          end else if (stop_drive || !area_ok) begin
            state <= next_hold ? dpcs_hold : dpcs_idle;
          end else begin
            tmr <= tmr - CW'(1);
          end
        end
        dpcs_fail: begin
          if (tmr == CW'(1)) begin
            state <= dpcs_idle;
          end else begin
            tmr <= tmr - CW'(1);
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // motor command
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      power_close_on    <= 1'b0;
      power_close_force <= '0;
      hold_on           <= 1'b0;
    end else begin
      power_close_on <= state == dpcs_drive && !stop_drive;
      hold_on        <= state == dpcs_hold && next_hold;
      if (latch_mode) begin
        power_close_force <= force_setting >> 1;
      end else begin
        power_close_force <= force_setting;
      end
    end
  end

  // ---------------------------------------------------------------
  // activation pulse and indicators
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_cnt        <= '0;
      activation_out <= 1'b0;
      led_fail       <= 1'b0;
    end else begin
      if (state == dpcs_drive && din.overcurrent) begin
        act_cnt <= CW'(ACT_CYC);
      end else if (act_cnt != '0) begin
        act_cnt <= act_cnt - CW'(1);
      end
      activation_out <= act_cnt != '0;
      led_fail       <= state == dpcs_fail;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flash_cnt <= '0;
      flash     <= 1'b0;
    end else if (flash_cnt == CW'(FLASH_CYC - 1)) begin
      flash_cnt <= '0;
      flash     <= !flash;
    end else begin
      flash_cnt <= flash_cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      led_trigger <= 1'b0;
      led_force   <= 1'b0;
      led_sel     <= '0;
    end else begin
      led_trigger <= din.trigger;
      led_force   <= (state == dpcs_drive) ||
                     (state == dpcs_hold && flash);
      led_sel     <= '{latch: sel == dpcs_sel_latch,
                       close: sel == dpcs_sel_close,
                       both:  sel == dpcs_sel_both};
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_cancel_stops: assert property (@(posedge sys_clk) disable iff (rst)
    din.cancel |=> ##1 !power_close_on)
    else $error("power close on under cancel");
  a_closed_ends: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpcs_drive && din.closed) |=> state != dpcs_drive)
    else $error("drive kept after door closed");
  a_hold_drop: assert property (@(posedge sys_clk) disable iff (rst)
    (!din.hold_jmp || !din.closed) |=> ##1 !hold_on)
    else $error("hold kept without cause");
  a_bk_block: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpcs_idle && din.backcheck && !din.bk_jmp)
      |=> state != dpcs_delay)
    else $error("engage at back-check without option");
  a_no_trig: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpcs_idle && !din.trigger) |=> state != dpcs_delay)
    else $error("delay without trigger");
  a_fail_led: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpcs_drive && din.overcurrent)
      |=> state == dpcs_fail ##1 (led_fail && activation_out))
    else $error("overcurrent not handled");
  a_fail_lock: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state == dpcs_fail) |-> (state == dpcs_fail) [*8])
    else $error("fail lockout too short");
  a_force_led: assert property (@(posedge sys_clk) disable iff (rst)
    power_close_on |-> led_force)
    else $error("force light off while driving");
  a_trig_led: assert property (@(posedge sys_clk) disable iff (rst)
    din.trigger |=> led_trigger)
    else $error("trigger light missing");
endmodule

/* dpcs_main_ctrl.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// main control and door contacts
// ------------------------------------------------
module dpcs_main_ctrl
  import dpcs_pkg::*;
(
  // clock
  input  wire logic     sys_clk,
  // contact levels set by the bench
  input  wire dpcs_in_t contacts,
  // re-open request from the module
  input  wire logic     activation_out,
  // contact levels at the module
  output dpcs_in_t      raw_in
);
  logic reopen;

  // main control re-opens one cycle after the request
  always_ff @(posedge sys_clk) begin
    reopen <= activation_out;
  end

  always_comb begin
    raw_in = contacts;
    raw_in.activation = contacts.activation | reopen;
  end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench
  import dpcs_pkg::*;
;
  typedef struct {
    logic [1:0] sel;
    logic [8:0] in;
    logic       on;
    int         to;
  } dpcs_row_t;

  localparam logic [8:0] lp_cancel = 9'h100;
  localparam logic [8:0] lp_closed = 9'h080;
  localparam logic [8:0] lp_bk     = 9'h040;
  localparam logic [8:0] lp_latch  = 9'h020;
  localparam logic [8:0] lp_act    = 9'h010;
  localparam logic [8:0] lp_trig   = 9'h008;
  localparam logic [8:0] lp_hold   = 9'h004;
  localparam logic [8:0] lp_bkj    = 9'h002;
  localparam logic [8:0] lp_oc     = 9'h001;
  localparam int         lp_short  = 20;

  logic          sys_clk;
  logic          rst;
  logic [1:0]    selector;
  logic [7:0]    force_setting;
  dpcs_in_t      cont;
  dpcs_in_t      raw_in;
  logic          power_close_on;
  logic [7:0]    power_close_force;
  logic          hold_on;
  logic          activation_out;
  logic          led_trigger;
  logic          led_force;
  logic          led_fail;
  dpcs_led_sel_t led_sel;
  logic [3:0]    obs;
  int            bad_count = 0;
  int            n_checks = 0;
  int            cyc = 0;

  dpcs_row_t rows [12] = '{
    '{2'h1, lp_trig | lp_latch, 1'h1, 30},
    '{2'h1, lp_trig, 1'h0, 0},
    '{2'h2, lp_trig, 1'h0, 0},
    '{2'h3, lp_trig | lp_latch, 1'h1, 30},
    '{2'h2, lp_trig | lp_bk, 1'h0, 0},
    '{2'h2, lp_trig, 1'h1, 60},
    '{2'h3, lp_trig, 1'h1, 60},
    '{2'h2, lp_trig | lp_bk | lp_bkj, 1'h1, 60},
    '{2'h3, lp_trig | lp_bk | lp_bkj, 1'h0, 0},
    '{2'h0, lp_trig | lp_latch, 1'h0, 0},
    '{2'h3, lp_trig | lp_latch | lp_cancel, 1'h0, 0},
    '{2'h2, lp_trig | lp_latch, 1'h0, 0}
  };

  assign obs = {activation_out, led_fail, hold_on, power_close_on};

  // ------------------------------------------------
  // design and far side
  // ------------------------------------------------
  dpcs_sequencer #(
    .DELAY_CYC   (lp_short),
    .FAIL_CYC    (lp_short),
    .LATCH_TO_CYC(30),
    .CLOSE_TO_CYC(60),
    .DEB_CYC     (2),
    .FLASH_CYC   (4),
    .ACT_CYC     (5)
  ) dpcs_sequencer_inst (
    .sys_clk          (sys_clk),
    .rst              (rst),
    .raw_in           (raw_in),
    .selector         (selector),
    .force_setting    (force_setting),
    .power_close_on   (power_close_on),
    .power_close_force(power_close_force),
    .hold_on          (hold_on),
    .activation_out   (activation_out),
    .led_trigger      (led_trigger),
    .led_force        (led_force),
    .led_fail         (led_fail),
    .led_sel          (led_sel)
  );

  dpcs_main_ctrl dpcs_main_ctrl_inst (
    .sys_clk       (sys_clk),
    .contacts      (cont),
    .activation_out(activation_out),
    .raw_in        (raw_in)
  );

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic set_in(input logic [1:0] s, input logic [8:0] v);
    @(posedge sys_clk);
    selector <= s;
    cont     <= v;
  endtask

  task automatic wait_obs(input int k, input logic lvl, input int lim,
                          output logic got);
    got = 1'h0;
    for (int i = 0; i < lim && !got; i++) begin
      step;
      got = (obs[k] === lvl);
    end
  endtask

  task automatic run_row(input dpcs_row_t r);
    logic got;
    int   n;
    set_in(r.sel, r.in);
    wait_obs(0, 1'h1, 45, got);
    check(got, r.on);
    check(led_sel, {r.sel == 2'h1, r.sel == 2'h2, r.sel == 2'h3});
    if (got) begin
      check(power_close_force, ((r.in & lp_latch) != 0 && (r.in & lp_bk) == 0)
            ? force_setting >> 1 : force_setting);
      check(led_force, 1'h1);
      check(led_trigger, 1'h1);
      n = 1;
      while (power_close_on === 1'h1 && n < 100) begin
        step;
        n++;
      end
      check(n >= r.to - 2 && n <= r.to + 2, 1'h1);
    end
    set_in(r.sel, 9'h000);
    repeat (12) step;
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run;
    end
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    logic       got;
    logic       lf;
    int         n;
    logic [8:0] ends [2];
    logic [8:0] rel [4];
    ends = '{lp_act, lp_closed};
    rel = '{lp_closed | lp_hold | lp_act, lp_closed | lp_hold | lp_cancel,
            lp_hold, lp_closed};
    rst = 1'h1;
    selector = 2'h0;
    cont = 9'h000;
    force_setting = 8'hc8;
    repeat (20) @(posedge sys_clk);
    #1;
    check({obs, led_sel, led_trigger, led_force}, 9'h000);
    @(posedge sys_clk) rst <= 1'h0;
    foreach (rows[i]) run_row(rows[i]);
    // glitch ignored, delay restarts in full
    set_in(2'h1, lp_latch | lp_trig);
    set_in(2'h1, lp_latch);
    repeat (6) begin
      step;
      check(led_trigger, 1'h0);
    end
    set_in(2'h1, lp_latch | lp_trig);
    repeat (12) step;
    check(led_trigger, 1'h1);
    check(power_close_on, 1'h0);
    set_in(2'h1, lp_latch);
    repeat (8) step;
    set_in(2'h1, lp_latch | lp_trig);
    wait_obs(0, 1'h1, 19, got);
    check(got, 1'h0);
    wait_obs(0, 1'h1, 25, got);
    check(got, 1'h1);
    // overcurrent while driving
    set_in(2'h1, lp_latch | lp_trig | lp_oc);
    wait_obs(2, 1'h1, 8, got);
    check({got, activation_out, power_close_on}, 9'h006);
    set_in(2'h1, lp_latch | lp_trig);
    wait_obs(0, 1'h1, 25, got);
    check(got, 1'h0);
    set_in(2'h1, 9'h000);
    repeat (50) step;
    // activation and door closed end a drive
    for (int k = 0; k < 2; k++) begin
      set_in(2'h1, lp_latch | lp_trig);
      wait_obs(0, 1'h1, 45, got);
      set_in(2'h1, lp_latch | lp_trig | ends[k]);
      wait_obs(0, 1'h0, 8, got);
      check({got, hold_on}, 9'h002);
      set_in(2'h1, 9'h000);
      repeat (12) step;
    end
    // hold and each way of ending it
    for (int k = 0; k < 4; k++) begin
      set_in(2'h3, lp_closed | lp_hold);
      wait_obs(1, 1'h1, 10, got);
      check({got, power_close_on}, 9'h002);
      n = 0;
      repeat (20) begin
        lf = led_force;
        step;
        n += (led_force !== lf);
      end
      check(n >= 2, 1'h1);
      set_in(2'h3, rel[k]);
      wait_obs(1, 1'h0, 10, got);
      check(got, 1'h1);
      set_in(2'h3, 9'h000);
      repeat (12) step;
    end
    // reset in mid-drive forgets the back-check switch
    set_in(2'h2, lp_trig);
    wait_obs(0, 1'h1, 45, got);
    check(got, 1'h1);
    @(posedge sys_clk) rst <= 1'h1;
    cont <= 9'h000;
    repeat (2) step;
    check(obs, 4'h0);
    @(posedge sys_clk) rst <= 1'h0;
    run_row(rows[2]);
    complete_run;
  end
endmodule
